// ===== rtl/csr_reporter.sv
/*
 * csr_reporter: saves and restores context images and reports each switch whose reason bit in reason_mask is clear.
 * assumes a memory port that holds ack for one cycle per accepted word and
 * a scheduler that hands over one switch request at a time.
 */
`timescale 1ns/1ps

module csr_reporter
    import csr_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic          sw_valid,
    output logic               sw_ready,
    input  wire csr_req_t      sw_req,
    input  wire logic [5:0]    reason_mask,
    input  wire logic [31:0]   gsp_base,
    input  wire logic [11:0]   eng_qwords,
    input  wire logic [63:0]   save_qw,
    output logic               save_take,
    output logic               rest_valid,
    output logic [63:0]        rest_qw,
    output logic               rest_engine,
    output logic               mem_req,
    output logic               mem_we,
    output logic [7:0]         mem_be,
    output logic [31:0]        mem_addr,
    output logic [63:0]        mem_wdata,
    input  wire logic          mem_ack,
    input  wire logic [63:0]   mem_rdata,
    output logic               ctx_irq,
    output logic               busy
);

    typedef struct packed {
        csr_state_t        st;
        logic [11:0]       cnt;
        csr_req_t          rq;
        csr_mem_t          mem;
        logic [3:0]        ptr;
        logic              inhibit;
        logic              rv;
        logic [63:0]       rd;
        logic              reng;
        logic              irq;
    } csr_regs_t;

    csr_regs_t s_r;
    csr_regs_t s_nxt;

    function automatic logic [31:0] csr_qw_addr(input logic [31:0] base,
                                                input logic [11:0] idx);
        csr_qw_addr = base + {17'h0, idx, 3'h0};
    endfunction

    function automatic logic [63:0] csr_status(input csr_req_t r);
        csr_status_t w;
        w           = '0;
        w.detail    = r.detail;
        w.from_id   = r.out_id;
        w.to_id     = r.in_id;
        w.new_queue = 1'b1;
        case (r.kind)
            CSR_K_I2A:
            begin
                w.detail  = CSR_DET_DONE;
                w.from_id = CSR_IDLE_ID;
            end
            CSR_K_P2I:
            begin
                w.to_id = CSR_IDLE_ID;
                if (!r.save_out)
                    w.from_id = CSR_IDLE_ID;
            end
            CSR_K_LITE: w.to_id = r.out_id;
            CSR_K_SYNC: w.new_queue = 1'b0;
            CSR_K_A2I:
            begin
                w.new_queue = 1'b0;
                w.to_id     = CSR_IDLE_ID;
            end
            default:    w.new_queue = 1'b1;
        endcase
        csr_status = w;
    endfunction

    function automatic csr_state_t csr_after_save(input csr_req_t r,
                                                 input logic [5:0] m);
        if (r.load_in)
            csr_after_save = CSR_S_REST_RING;
        else if (m[r.kind])
            csr_after_save = CSR_S_IDLE;
        else
            csr_after_save = CSR_S_WR_STAT;
    endfunction

    logic last_ring;
    logic last_eng;

    always_comb
    begin
        s_nxt     = s_r;
        s_nxt.rv  = 1'b0;
        s_nxt.irq = 1'b0;
        save_take = 1'b0;
        last_ring = (s_r.cnt == CSR_RING_QW - 12'h001);
        last_eng  = (s_r.cnt == eng_qwords - 12'h001);
        case (s_r.st)
            CSR_S_IDLE:
            begin
                if (sw_valid)
                begin
                    s_nxt.rq      = sw_req;
                    s_nxt.cnt     = '0;
                    s_nxt.inhibit = 1'b0;
                    if (sw_req.save_out)
                        s_nxt.st = CSR_S_SAVE_RING;
                    else
                        s_nxt.st = csr_after_save(sw_req, reason_mask);
                end
            end
            CSR_S_SAVE_RING, CSR_S_SAVE_ENG:
            begin
                if (!s_r.mem.req)
                begin
                    save_take       = 1'b1;
                    s_nxt.mem.req   = 1'b1;
                    s_nxt.mem.we    = 1'b1;
                    s_nxt.mem.be    = CSR_BE_ALL;
                    s_nxt.mem.wdata = save_qw;
                    if (s_r.st == CSR_S_SAVE_RING)
                        s_nxt.mem.addr = csr_qw_addr(s_r.rq.out_base + CSR_PPSP_BYTES,
                                                     s_r.cnt);
                    else
                        s_nxt.mem.addr = csr_qw_addr(s_r.rq.out_base + CSR_PPSP_BYTES
                                                     + CSR_RING_BYTES, s_r.cnt);
                end
                else if (mem_ack)
                begin
                    s_nxt.mem.req = 1'b0;
                    s_nxt.cnt     = s_r.cnt + 12'h001;
                    if (s_r.st == CSR_S_SAVE_RING && last_ring)
                    begin
                        s_nxt.cnt = '0;
                        if (eng_qwords != '0)
                            s_nxt.st = CSR_S_SAVE_ENG;
                        else
                            s_nxt.st = csr_after_save(s_r.rq, reason_mask);
                    end
                    else if (s_r.st == CSR_S_SAVE_ENG && last_eng)
                    begin
                        s_nxt.cnt = '0;
                        s_nxt.st  = csr_after_save(s_r.rq, reason_mask);
                    end
                end
            end
            CSR_S_REST_RING, CSR_S_REST_ENG:
            begin
                if (!s_r.mem.req)
                begin
                    s_nxt.mem.req = 1'b1;
                    s_nxt.mem.we  = 1'b0;
                    s_nxt.mem.be  = CSR_BE_ALL;
                    if (s_r.st == CSR_S_REST_RING)
                        s_nxt.mem.addr = csr_qw_addr(s_r.rq.in_base + CSR_PPSP_BYTES,
                                                     s_r.cnt);
                    else
                        s_nxt.mem.addr = csr_qw_addr(s_r.rq.in_base + CSR_PPSP_BYTES
                                                     + CSR_RING_BYTES, s_r.cnt);
                end
                else if (mem_ack)
                begin
                    s_nxt.mem.req = 1'b0;
                    s_nxt.rv      = 1'b1;
                    s_nxt.rd      = mem_rdata;
                    s_nxt.reng    = (s_r.st == CSR_S_REST_ENG);
                    s_nxt.cnt     = s_r.cnt + 12'h001;
                    if (s_r.st == CSR_S_REST_RING && s_r.cnt == CSR_CTRL_QW)
                        s_nxt.inhibit = mem_rdata[CSR_INHIBIT_B];
                    if ((s_r.st == CSR_S_REST_RING && last_ring)
                        || (s_r.st == CSR_S_REST_ENG && last_eng))
                    begin
                        s_nxt.cnt = '0;
                        if (s_r.st == CSR_S_REST_RING && !s_nxt.inhibit
                            && eng_qwords != '0)
                            s_nxt.st = CSR_S_REST_ENG;
                        else if (reason_mask[s_r.rq.kind])
                            s_nxt.st = CSR_S_IDLE;
                        else
                            s_nxt.st = CSR_S_WR_STAT;
                    end
                end
            end
            CSR_S_WR_STAT:
            begin
                if (!s_r.mem.req)
                begin
                    s_nxt.mem.req   = 1'b1;
                    s_nxt.mem.we    = 1'b1;
                    s_nxt.mem.be    = CSR_BE_ALL;
                    s_nxt.mem.addr  = csr_qw_addr(gsp_base + {CSR_BUF_DW[29:0], 2'h0},
                                                  {8'h0, s_r.ptr});
                    s_nxt.mem.wdata = csr_status(s_r.rq);
                end
                else if (mem_ack)
                begin
                    s_nxt.mem.req = 1'b0;
                    s_nxt.st      = CSR_S_WR_IDX;
                end
            end
            CSR_S_WR_IDX:
            begin
                if (!s_r.mem.req)
                begin
                    s_nxt.mem.req   = 1'b1;
                    s_nxt.mem.we    = 1'b1;
                    s_nxt.mem.be    = CSR_BE_LOW;
                    s_nxt.mem.addr  = gsp_base + {CSR_IDX_DW[29:0], 2'h0};
                    s_nxt.mem.wdata = {60'h0, s_r.ptr};
                end
                else if (mem_ack)
                begin
                    s_nxt.mem.req = 1'b0;
                    s_nxt.irq     = 1'b1;
                    s_nxt.st      = CSR_S_IDLE;
                    if (s_r.ptr == CSR_LAST_ENTRY)
                        s_nxt.ptr = '0;
                    else
                        s_nxt.ptr = s_r.ptr + 4'h1;
                end
            end
            default: s_nxt.st = CSR_S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign sw_ready    = (s_r.st == CSR_S_IDLE);
    assign busy        = (s_r.st != CSR_S_IDLE);
    assign mem_req     = s_r.mem.req;
    assign mem_we      = s_r.mem.we;
    assign mem_be      = s_r.mem.be;
    assign mem_addr    = s_r.mem.addr;
    assign mem_wdata   = s_r.mem.wdata;
    assign rest_valid  = s_r.rv;
    assign rest_qw     = s_r.rd;
    assign rest_engine = s_r.reng;
    assign ctx_irq     = s_r.irq;

    csr_status_t sw_w;
    assign sw_w = csr_status_t'(s_r.mem.wdata);

    AST_RING_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(mem_req) && s_r.st == CSR_S_REST_RING && s_r.cnt == '0
        |-> mem_addr == s_r.rq.in_base + CSR_PPSP_BYTES)
        else $error("ring restore does not start after status page");
    AST_ENG_AFTER_RING: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.st == CSR_S_SAVE_ENG && $changed(s_r.st) |-> $past(s_r.st) == CSR_S_SAVE_RING)
        else $error("engine save not preceded by ring save");
    AST_INHIBIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.st == CSR_S_REST_ENG |-> !s_r.inhibit)
        else $error("engine restored while inhibited");
    AST_MASKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.st == CSR_S_WR_STAT |-> !reason_mask[s_r.rq.kind])
        else $error("status written for masked reason");
    AST_P2I_IDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.st == CSR_S_WR_STAT && mem_req && s_r.rq.kind == CSR_K_P2I
        |-> sw_w.to_id == CSR_IDLE_ID && sw_w.new_queue)
        else $error("preempt to idle word wrong");
    AST_A2I_NQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.st == CSR_S_WR_STAT && mem_req && s_r.rq.kind == CSR_K_A2I
        |-> !sw_w.new_queue && sw_w.to_id == CSR_IDLE_ID)
        else $error("active to idle word wrong");
    AST_LITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.st == CSR_S_WR_STAT && mem_req && s_r.rq.kind == CSR_K_LITE
        |-> sw_w.to_id == sw_w.from_id)
        else $error("lite restore ids differ");
    AST_STAT_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.st == CSR_S_WR_STAT && mem_req
        |-> mem_addr == gsp_base + {CSR_BUF_DW[29:0], 2'h0} + {25'h0, s_r.ptr, 3'h0})
        else $error("status entry address wrong");
    AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(s_r.ptr) |-> s_r.ptr == ($past(s_r.ptr) == CSR_LAST_ENTRY ? 4'h0
                                          : $past(s_r.ptr) + 4'h1))
        else $error("write pointer step wrong");
    AST_IDX_BYTE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.st == CSR_S_WR_IDX && mem_req |-> mem_wdata[7:4] == 4'h0 && mem_be == CSR_BE_LOW)
        else $error("index byte high bits set");
    AST_IRQ_ORDER: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctx_irq |-> $past(s_r.st) == CSR_S_WR_IDX && $past(mem_ack))
        else $error("interrupt before index write done");

    COV_IRQ: cover property (@(posedge clk_sys) disable iff (!rst_n) ctx_irq);
    COV_WRAP: cover property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.ptr == CSR_LAST_ENTRY ##1 s_r.ptr == 4'h0);
    COV_ENG_REST: cover property (@(posedge clk_sys) disable iff (!rst_n)
        rest_valid && rest_engine);
    COV_INHIBIT: cover property (@(posedge clk_sys) disable iff (!rst_n)
        s_r.st == CSR_S_REST_RING && s_nxt.st == CSR_S_WR_STAT && s_r.inhibit);

endmodule

// ===== rtl/csr_pkg.sv
/*
 * csr_pkg: constants and types of the context switch status reporter.
 * assumes byte addresses of 32 bits and 64-bit memory words (qwords).
 */
package csr_pkg;
    localparam int unsigned      CSR_ID_W       = 11;
    localparam int unsigned      CSR_CNT_W      = 12;
    localparam logic [10:0]      CSR_IDLE_ID    = 11'h7ff;
    localparam logic [31:0]      CSR_PPSP_BYTES = 32'h0000_1000;
    localparam int unsigned      CSR_LINE_QW    = 8;
    localparam int unsigned      CSR_RING_LINES = 5;
    localparam logic [11:0]      CSR_RING_QW    = 12'(CSR_RING_LINES * CSR_LINE_QW);
    localparam logic [31:0]      CSR_RING_BYTES = 32'(CSR_RING_LINES * CSR_LINE_QW * 8);
    localparam logic [11:0]      CSR_CTRL_QW    = 12'h001;
    localparam int unsigned      CSR_INHIBIT_B  = 0;
    localparam logic [31:0]      CSR_BUF_DW     = 32'h0000_0028;
    localparam logic [31:0]      CSR_IDX_DW     = 32'h0000_0047;
    localparam logic [3:0]       CSR_ENTRIES    = 4'hc;
    localparam logic [3:0]       CSR_LAST_ENTRY = 4'hb;
    localparam logic [7:0]       CSR_BE_ALL     = 8'hff;
    localparam logic [7:0]       CSR_BE_LOW     = 8'h01;
    localparam logic [2:0]       CSR_DET_DONE   = 3'h0;

    typedef enum logic [2:0] {
        CSR_K_I2A  = 3'h0,
        CSR_K_P2I  = 3'h1,
        CSR_K_NEWQ = 3'h2,
        CSR_K_LITE = 3'h3,
        CSR_K_SYNC = 3'h4,
        CSR_K_A2I  = 3'h5
    } csr_kind_t;

    typedef enum logic [2:0] {
        CSR_S_IDLE      = 3'h0,
        CSR_S_SAVE_RING = 3'h1,
        CSR_S_SAVE_ENG  = 3'h3,
        CSR_S_REST_RING = 3'h2,
        CSR_S_REST_ENG  = 3'h6,
        CSR_S_WR_STAT   = 3'h7,
        CSR_S_WR_IDX    = 3'h5
    } csr_state_t;

    typedef struct packed {
        csr_kind_t         kind;
        logic [10:0]       out_id;
        logic [10:0]       in_id;
        logic [2:0]        detail;
        logic              save_out;
        logic              load_in;
        logic [31:0]       out_base;
        logic [31:0]       in_base;
    } csr_req_t;

    typedef struct packed {
        logic [37:0]       rsvd;
        logic              new_queue;
        logic [2:0]        detail;
        logic [10:0]       from_id;
        logic [10:0]       to_id;
    } csr_status_t;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [7:0]        be;
        logic [31:0]       addr;
        logic [63:0]       wdata;
    } csr_mem_t;
endpackage

// ===== tb/csr_mem_model.sv
/*
 * csr_mem_model: behavioural graphics memory holding context images and status page.
 * assumes one word request at a time, held by the requester until its ack.
 */
`timescale 1ns/1ps

module csr_mem_model
(
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    input  wire logic [3:0]    dly,
    input  wire logic          mem_req,
    input  wire logic          mem_we,
    input  wire logic [7:0]    mem_be,
    input  wire logic [31:0]   mem_addr,
    input  wire logic [63:0]   mem_wdata,
    output logic               mem_ack,
    output logic [63:0]        mem_rdata
);
    logic [63:0] mem [logic [31:0]];
    logic [31:0] wr_log [$];
    logic [31:0] rd_log [$];
    logic [3:0]  cnt;
    logic [63:0] cur;

    // one ack per word after dly waiting cycles; read data scrambled outside ack
    always @(posedge clk_sys)
    begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!rst_n)
        begin
            cnt       <= 4'h0;
            mem_rdata <= 64'h0;
        end
        else if (mem_req && !mem_ack)
        begin
            if (cnt < dly)
                cnt <= cnt + 4'h1;
            else
            begin
                cnt     <= 4'h0;
                mem_ack <= 1'b1;
                cur     = mem.exists(mem_addr) ? mem[mem_addr] : 64'h0;
                if (mem_we)
                begin
                    for (int b = 0; b < 8; b++)
                        if (mem_be[b])
                            cur[b*8 +: 8] = mem_wdata[b*8 +: 8];
                    mem[mem_addr] = cur;
                    wr_log.push_back(mem_addr);
                end
                else
                begin
                    mem_rdata <= cur;
                    rd_log.push_back(mem_addr);
                end
            end
        end
    end
endmodule

// ===== tb/csr_reporter_tb.sv
/*
 * csr_reporter_tb: self-checking bench of the context switch status reporter.
 * assumes csr_mem_model as memory; inputs change on the falling edge.
 */
`timescale 1ns/1ps

module csr_reporter_tb
    import csr_pkg::*;
;
    localparam logic [31:0] GSP    = 32'h0002_0000;
    localparam logic [31:0] OUT_B  = 32'h0010_0000;
    localparam logic [31:0] IN_B   = 32'h0020_0000;
    localparam logic [63:0] SAVE_B = 64'h5a5a_0000_0000_0000;

    logic        clk_sys, rst_n, sw_valid, sw_ready, save_take, rest_valid, rest_engine;
    logic        mem_req, mem_we, mem_ack, ctx_irq, busy;
    csr_req_t    sw_req;
    logic [5:0]  reason_mask;
    logic [11:0] eng_qwords;
    logic [7:0]  mem_be;
    logic [31:0] mem_addr;
    logic [63:0] save_qw, rest_qw, mem_wdata, mem_rdata;
    logic [3:0]  dly, ptr;
    logic [63:0] rest_q [$];
    int          fail_count, n_checks, irq_cnt, eng_cnt;
    int          save_cnt = 0;

    csr_reporter csr_reporter_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .sw_valid(sw_valid), .sw_ready(sw_ready),
        .sw_req(sw_req), .reason_mask(reason_mask), .gsp_base(GSP), .eng_qwords(eng_qwords),
        .save_qw(save_qw), .save_take(save_take), .rest_valid(rest_valid), .rest_qw(rest_qw),
        .rest_engine(rest_engine), .mem_req(mem_req), .mem_we(mem_we), .mem_be(mem_be),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .ctx_irq(ctx_irq), .busy(busy));

    csr_mem_model csr_mem_model_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .dly(dly), .mem_req(mem_req), .mem_we(mem_we),
        .mem_be(mem_be), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // interrupt, restore and save-take monitor
    always @(posedge clk_sys)
    begin
        if (ctx_irq === 1'b1)
        begin
            irq_cnt++;
            chk(64'(csr_mem_model_i.wr_log[$]), 64'(GSP + 32'h11c));
        end
        if (rest_valid === 1'b1)
        begin
            rest_q.push_back(rest_qw);
            if (rest_engine === 1'b1)
                eng_cnt++;
        end
        if (save_take === 1'b1)
            save_cnt <= save_cnt + 1;
    end

    always @(negedge clk_sys)
        save_qw <= SAVE_B + 64'(save_cnt);

    task automatic run_sw(input csr_kind_t k, input logic [10:0] o, input logic [10:0] i,
                          input logic [2:0] d, input logic so, input logic li);
        int n;
        irq_cnt = 0;
        eng_cnt = 0;
        n       = 0;
        rest_q.delete();
        csr_mem_model_i.wr_log.delete();
        csr_mem_model_i.rd_log.delete();
        @(negedge clk_sys);
        sw_valid = 1'b1;
        sw_req   = '{k, o, i, d, so, li, OUT_B, IN_B};
        while (sw_ready !== 1'b1 && n < 50)
        begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        sw_valid = 1'b0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        if (n >= 3000)
            fail_count++;
    endtask

    task automatic rpt(input logic nq, input logic [2:0] d, input logic [10:0] f,
                       input logic [10:0] t, input logic uf);
        logic [31:0] a;
        logic [63:0] got;
        a   = GSP + 32'h0a0 + {25'h0, ptr, 3'h0};
        got = csr_mem_model_i.mem[a];
        if (!uf)
            got[21:11] = f;
        chk(64'(csr_mem_model_i.wr_log[$-1]), 64'(a));
        chk(got, {38'h0, nq, d, f, t});
        chk(csr_mem_model_i.mem[GSP + 32'h11c], {56'hff_ffff_ffff_ffff, 4'h0, ptr});
        chk(64'(irq_cnt), 64'h1);
        ptr = (ptr == 4'hb) ? 4'h0 : ptr + 4'h1;
    endtask

    task automatic sk(input csr_kind_t k, input logic [10:0] o, input logic [10:0] i,
                      input logic [2:0] d, input logic so, input logic nq,
                      input logic [10:0] f, input logic [10:0] t, input logic uf);
        run_sw(k, o, i, d, so, 1'b0);
        rpt(nq, d, f, t, uf);
    endtask

    task automatic sc_idle_active();
        sk(CSR_K_I2A, 11'h123, 11'h0ab, 3'h0, 1'b0, 1'b1, CSR_IDLE_ID, 11'h0ab, 1'b1);
    endtask

    task automatic sc_preempt_idle();
        sk(CSR_K_P2I, 11'h0ab, 11'h055, 3'h3, 1'b1, 1'b1, 11'h0ab, CSR_IDLE_ID, 1'b1);
        sk(CSR_K_P2I, 11'h0ab, 11'h055, 3'h3, 1'b0, 1'b1, CSR_IDLE_ID, CSR_IDLE_ID, 1'b1);
    endtask

    task automatic sc_new_queue();
        sk(CSR_K_NEWQ, 11'h0ab, 11'h7bc, 3'h0, 1'b1, 1'b1, 11'h0ab, 11'h7bc, 1'b1);
        sk(CSR_K_NEWQ, 11'h0ab, 11'h7bc, 3'h5, 1'b1, 1'b1, 11'h0ab, 11'h7bc, 1'b1);
        sk(CSR_K_NEWQ, 11'h0ab, 11'h7bc, 3'h2, 1'b1, 1'b1, 11'h0ab, 11'h7bc, 1'b1);
    endtask

    task automatic sc_lite();
        sk(CSR_K_LITE, 11'h0ab, 11'h0cd, 3'h0, 1'b1, 1'b1, 11'h0ab, 11'h0ab, 1'b1);
    endtask

    task automatic sc_sync();
        sk(CSR_K_SYNC, 11'h0ab, 11'h7ac, 3'h0, 1'b1, 1'b0, 11'h0ab, 11'h7ac, 1'b1);
        sk(CSR_K_SYNC, 11'h0ab, 11'h7ac, 3'h4, 1'b1, 1'b0, 11'h0ab, 11'h7ac, 1'b1);
        sk(CSR_K_SYNC, 11'h0ab, 11'h7ac, 3'h1, 1'b1, 1'b0, 11'h0ab, 11'h7ac, 1'b1);
    endtask

    task automatic sc_active_idle();
        sk(CSR_K_A2I, 11'h0ab, 11'h033, 3'h5, 1'b1, 1'b0, 11'h0ab, CSR_IDLE_ID, 1'b1);
        sk(CSR_K_A2I, 11'h0ab, 11'h033, 3'h2, 1'b1, 1'b0, 11'h0ab, CSR_IDLE_ID, 1'b1);
    endtask

    task automatic sc_mask();
        for (int k = 0; k < 6; k++)
        begin
            reason_mask = 6'(1 << k);
            run_sw(csr_kind_t'(k), 11'h0ab, 11'h0cd, 3'h0, 1'b0, 1'b0);
            chk(64'(irq_cnt), 64'h0);
            chk(64'(csr_mem_model_i.wr_log.size()), 64'h0);
        end
        reason_mask = 6'h3e;
        sk(CSR_K_I2A, 11'h0ab, 11'h0cd, 3'h0, 1'b0, 1'b1, CSR_IDLE_ID, 11'h0cd, 1'b1);
        reason_mask = 6'h00;
    endtask

    task automatic sc_save(input logic inh, input logic [3:0] dl);
        int s0;
        int nrd;
        dly        = dl;
        eng_qwords = 12'h003;
        for (int j = 0; j < 43; j++)
            csr_mem_model_i.mem[IN_B + 32'h1000 + 32'(j * 8)] = 64'h7700 + 64'(j);
        csr_mem_model_i.mem[IN_B + 32'h1008] = {63'h91a, inh};
        s0  = save_cnt;
        nrd = inh ? 40 : 43;
        run_sw(CSR_K_SYNC, 11'h0ab, 11'h0cd, 3'h0, 1'b1, 1'b1);
        for (int j = 0; j < 43; j++)
        begin
            chk(64'(csr_mem_model_i.wr_log[j]), 64'(OUT_B + 32'h1000 + 32'(j * 8)));
            chk(csr_mem_model_i.mem[OUT_B + 32'h1000 + 32'(j * 8)], SAVE_B + 64'(s0 + j));
        end
        chk(64'(csr_mem_model_i.rd_log.size()), 64'(nrd));
        chk(64'(rest_q.size()), 64'(nrd));
        for (int j = 0; j < nrd; j++)
        begin
            chk(64'(csr_mem_model_i.rd_log[j]), 64'(IN_B + 32'h1000 + 32'(j * 8)));
            chk(rest_q[j], csr_mem_model_i.mem[IN_B + 32'h1000 + 32'(j * 8)]);
        end
        chk(64'(eng_cnt), inh ? 64'h0 : 64'h3);
        rpt(1'b0, 3'h0, 11'h0ab, 11'h0cd, 1'b1);
        dly = 4'h0;
    endtask

    initial
    begin
        rst_n       = 1'b0;
        sw_valid    = 1'b0;
        sw_req      = '0;
        reason_mask = 6'h00;
        eng_qwords  = 12'h000;
        dly         = 4'h0;
        ptr         = 4'h0;
        fail_count  = 0;
        n_checks    = 0;
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk(64'({sw_ready, busy, mem_req, ctx_irq, rest_valid}), 64'h10);
        csr_mem_model_i.mem[GSP + 32'h11c] = '1;
        sc_idle_active();
        sc_preempt_idle();
        sc_new_queue();
        sc_lite();
        sc_sync();
        sc_active_idle();
        sc_mask();
        sc_save(1'b0, 4'h2);
        sc_save(1'b1, 4'h1);
        end_of_test();
    end

    initial
    begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        end_of_test();
    end
endmodule
